// ===== sim/tb_top.sv
// Purpose: Self-checking bench for the display fuse capability registers
// Assumes: Settle shortened to 1; inputs move 1 ns after each rising edge
// Notes: Expected fuse outputs are derived from the value last stored
module tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic function_level_reset = 1'b0;
	logic mmio_wr = 1'b0;
	logic mmio_rd = 1'b0;
	logic cfg_wr = 1'b0;
	logic cfg_rd = 1'b0;
	logic [31:0] fuse_pins = 32'h0;
	logic [31:0] mmio_wdata = 32'h0;
	logic [31:0] cfg_wdata = 32'h0;
	logic [19:0] mmio_addr = 20'h0;
	logic [11:0] cfg_addr = 12'h0;
	logic [31:0] rd_data;
	logic [31:0] d;
	logic [7:0] codec_id_lo;
	logic rd_valid, fuse_loaded, pipe_a_off, pipe_b_off, pipe_c_off;
	logic pm_off, panel_off, aux_display_feature_off, iso_decode_off;
	logic shared_virtual_memory_off;
	int failures = 0;
	int n_tests = 0;
	// 200 MHz system clock
	always #2.5 clk_sys = ~clk_sys;
	dfc_regs #(.SETTLE(1)) dut_u (.clk_sys(clk_sys), .rst(rst), .function_level_reset(function_level_reset),
		.fuse_pins(fuse_pins), .mmio_addr(mmio_addr), .mmio_wr(mmio_wr),
		.mmio_rd(mmio_rd), .mmio_wdata(mmio_wdata), .cfg_addr(cfg_addr),
		.cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_wdata(cfg_wdata),
		.rd_data(rd_data), .rd_valid(rd_valid), .fuse_loaded(fuse_loaded),
		.pipe_a_off(pipe_a_off), .pipe_b_off(pipe_b_off),
		.pipe_c_off(pipe_c_off), .pm_off(pm_off), .panel_off(panel_off),
		.aux_display_feature_off(aux_display_feature_off),
		.iso_decode_off(iso_decode_off), .codec_id_lo(codec_id_lo),
		.shared_virtual_memory_off(shared_virtual_memory_off));
	// Verdict and end of run, also reached when a wait runs out
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic tick;
		@(posedge clk_sys);
		#1;
	endtask
	// Global reset, one refused read before load, bounded wait for load
	task automatic do_rst(input logic [31:0] pins);
		rst = 1'b1;
		fuse_pins = pins;
		repeat (16) tick;
		rst = 1'b0;
		mmio_addr = dfc_pkg::FUSE_OFF;
		mmio_rd = 1'b1;
		tick;
		mmio_rd = 1'b0;
		chk({31'h0, rd_valid}, 32'h0);
		for (int i = 0; i < 20 && fuse_loaded !== 1'b1; i++) tick;
		if (fuse_loaded !== 1'b1) begin
			failures++;
			wrap_up;
		end
	endtask
	// One-cycle strobe; the answer stands in the cycle after the strobe
	task automatic rd(input bit cfg, input logic [19:0] a);
		cfg_addr = a[11:0];
		mmio_addr = a;
		cfg_rd = cfg;
		mmio_rd = !cfg;
		tick;
		chk({31'h0, rd_valid}, 32'h1);
		d = rd_data;
		cfg_rd = 1'b0;
		mmio_rd = 1'b0;
		tick;
	endtask
	task automatic wr(input bit cfg, input logic [19:0] a, input logic [31:0] v);
		cfg_addr = a[11:0];
		mmio_addr = a;
		cfg_wdata = v;
		mmio_wdata = v;
		cfg_wr = cfg;
		mmio_wr = !cfg;
		tick;
		cfg_wr = 1'b0;
		mmio_wr = 1'b0;
		tick;
	endtask
	// Reads the fuse word and compares every decoded output with its bit
	task automatic chk_fuse(input logic [31:0] v);
		rd(1'b0, dfc_pkg::FUSE_OFF);
		chk(d, v);
		chk({pipe_a_off, pipe_c_off, pm_off, panel_off}, {v[30], v[28:26]});
		chk({pipe_b_off, aux_display_feature_off, iso_decode_off}, {v[21:20], v[16]});
		chk(codec_id_lo, v[15:8]);
		chk(d[22], v[22]);
	endtask
	// Main sequence
	initial begin
		do_rst(32'h4C71_5A00);
		chk_fuse(32'h4C71_5A00);
		rd(1'b1, 20'h000E8);
		chk(d, 32'h0);
		rd(1'b0, 20'h51004);
		chk(d, 32'h0);
		$display("test load done");
		wr(1'b0, dfc_pkg::FUSE_OFF, 32'hB38E_A5FF);
		chk_fuse(32'hB38E_A5FF);
		function_level_reset = 1'b1;
		tick;
		function_level_reset = 1'b0;
		chk_fuse(32'hB38E_A5FF);
		$display("test fuse write and flr done");
		wr(1'b1, 20'h000E8, 32'hFFFF_FFFF);
		rd(1'b1, 20'h000E8);
		chk(d, 32'hFFFF_F77F);
		chk(shared_virtual_memory_off, 1'b1);
		wr(1'b1, 20'h000E8, 32'h0);
		chk(shared_virtual_memory_off, 1'b0);
		wr(1'b1, 20'h000E8, 32'h0100_0000);
		chk(shared_virtual_memory_off, 1'b1);
		$display("test capability word done");
		do_rst(32'h4C71_5A00);
		chk_fuse(32'h4C71_5A00);
		rd(1'b1, 20'h000E8);
		chk(d, 32'h0);
		chk(shared_virtual_memory_off, 1'b0);
		$display("test second reset done");
		wrap_up;
	end
endmodule // tb_top

// ===== verilog/dfc_fuse_loader.sv
// Purpose: Synchronise fuse and strap pins and time the post-reset load
// Assumes: Pins are static after global reset; they may change only then
// Notes: Issues exactly one load pulse per global reset
module dfc_fuse_loader #(
	parameter int WIDTH = dfc_pkg::DW,
	parameter int SETTLE = dfc_pkg::SETTLE_CYC
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic [WIDTH-1:0] fuse_pins,
	output logic [WIDTH-1:0] fuse_word,
	output logic load,
	output logic done
);
	logic [WIDTH-1:0] sync1_r;
	logic [WIDTH-1:0] sync2_r;
	logic [$clog2(SETTLE+1)-1:0] cnt_r;
	logic load_r;
	logic done_r;

	// Two-stage synchroniser; first stage feeds only the second
	always_ff @(posedge clk_sys) begin
		sync1_r <= fuse_pins;
		sync2_r <= sync1_r;
	end

	// Settle counter, then one load pulse; done stays high until reset
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			cnt_r <= '0;
			load_r <= 1'b0;
			done_r <= 1'b0;
		end else begin
			load_r <= 1'b0;
			if (!done_r && !load_r) begin
				if (cnt_r == ($clog2(SETTLE+1))'(SETTLE)) begin
					load_r <= 1'b1; // RULE_15
				end else begin
					cnt_r <= cnt_r + 1'b1;
				end
			end
			if (load_r) begin
				done_r <= 1'b1;
			end
		end
	end

	assign fuse_word = sync2_r;
	assign load = load_r;
	assign done = done_r;
endmodule // dfc_fuse_loader

// ===== verilog/dfc_pkg.sv
// Purpose: Shared constants for the display fuse capability registers
// Assumes: 32-bit registers, word-wide accesses only
// Notes: Offsets are byte addresses in their own address spaces
package dfc_pkg;
	// Address widths and register offsets
	localparam int MMIO_AW = 20;
	localparam int CFG_AW = 12;
	localparam logic [MMIO_AW-1:0] FUSE_OFF = 20'h51000;
	localparam logic [CFG_AW-1:0] CAPB_OFF = 12'h0E8;
	localparam int DW = 32;

	// Fuse register field positions
	localparam int PIPE_A_BIT = 30;
	localparam int PIPE_C_BIT = 28;
	localparam int PM_BIT = 27;
	localparam int PANEL_BIT = 26;
	localparam int SPARE_BIT = 22;
	localparam int PIPE_B_BIT = 21;
	localparam int AUX_DISP_BIT = 20;
	localparam int ISO_DEC_BIT = 16;
	localparam int CODEC_MSB = 15;
	localparam int CODEC_LSB = 8;

	// Capability word b layout: bits 11 and 7 are reserved, read as zero
	localparam int SVM_BIT = 24;
	localparam logic [DW-1:0] CAPB_RW_MASK = 32'hFFFF_F77F;
	localparam logic [DW-1:0] CAPB_RESET = 32'h0000_0000;
	localparam logic [DW-1:0] FUSE_RESET = 32'h0000_0000;
	localparam logic [DW-1:0] RD_UNMAPPED = 32'h0000_0000;

	// Cycles that fuse and strap pins must settle after global reset
	localparam int SETTLE_CYC = 4;
endpackage : dfc_pkg

// ===== verilog/dfc_regs.sv
// Purpose: Display fuse capability register and capability word b
// Assumes: rst is the global reset; flr is the function level reset
// Notes: One-cycle read answer; accesses before the fuse load are refused
// What this block does
// RULE_01 - 32-bit display fuse register at MMIO offset 0x51000 holds fuse settings
// RULE_02 - Fuse register survives function level reset; only global reset clears it
// RULE_03 - Bit 30: first display pipe disabled when 1
// RULE_04 - Bit 28: third display pipe disabled when 1
// RULE_05 - Bit 27: frame buffer compression and backlight saving disabled when 1
// RULE_06 - Bit 26: embedded panel and all combo physical-layer ports off when 1
// RULE_07 - Bit 22: spare bit, 0 enable, 1 disable, drives nothing
// RULE_08 - Bit 21: second display pipe disabled when 1
// RULE_09 - Bit 20: auxiliary display feature disabled when 1
// RULE_10 - Bit 16: isolated decode disabled when 1
// RULE_11 - Bits 15:8 hold low byte of audio codec device identifier
// RULE_12 - Codec field reset value meaningless; fuse download overwrites it
// RULE_13 - Capability word b bit 24 disables shared virtual memory when 1
// RULE_14 - Other capability word b fields are plain storage, zero default
// RULE_15 - Fuse fields load from fuse pins after global reset before reads
module dfc_regs #(
	parameter int SETTLE = dfc_pkg::SETTLE_CYC
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic function_level_reset,
	input wire logic [dfc_pkg::DW-1:0] fuse_pins,
	input wire logic [dfc_pkg::MMIO_AW-1:0] mmio_addr,
	input wire logic mmio_wr,
	input wire logic mmio_rd,
	input wire logic [dfc_pkg::DW-1:0] mmio_wdata,
	input wire logic [dfc_pkg::CFG_AW-1:0] cfg_addr,
	input wire logic cfg_wr,
	input wire logic cfg_rd,
	input wire logic [dfc_pkg::DW-1:0] cfg_wdata,
	output logic [dfc_pkg::DW-1:0] rd_data,
	output logic rd_valid,
	output logic fuse_loaded,
	output logic pipe_a_off,
	output logic pipe_b_off,
	output logic pipe_c_off,
	output logic pm_off,
	output logic panel_off,
	output logic aux_display_feature_off,
	output logic iso_decode_off,
	output logic [7:0] codec_id_lo,
	output logic shared_virtual_memory_off
);
	logic [dfc_pkg::DW-1:0] fuse_r;
	logic [dfc_pkg::DW-1:0] capb_r;
	logic [dfc_pkg::DW-1:0] rd_data_r;
	logic rd_valid_r;
	logic [dfc_pkg::DW-1:0] fuse_word;
	logic load;
	logic done;
	logic hit_fuse;
	logic hit_capb;

	dfc_fuse_loader #(
		.WIDTH(dfc_pkg::DW),
		.SETTLE(SETTLE)
	) u_loader (
		.clk_sys(clk_sys),
		.rst(rst),
		.fuse_pins(fuse_pins),
		.fuse_word(fuse_word),
		.load(load),
		.done(done)
	);

	// Address decode; nothing is accepted before the fuse load completes
	assign hit_fuse = done && (mmio_addr == dfc_pkg::FUSE_OFF); // RULE_01
	assign hit_capb = done && (cfg_addr == dfc_pkg::CAPB_OFF);

	// Fuse register: global reset only, flr deliberately not a term here
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			fuse_r <= dfc_pkg::FUSE_RESET; // RULE_02
		end else if (load) begin
			fuse_r <= fuse_word; // RULE_15 RULE_12
		end else if (mmio_wr && hit_fuse) begin
			fuse_r <= mmio_wdata; // RULE_01
		end
	end

	// Capability word b: plain storage, reserved bits forced to zero
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			capb_r <= dfc_pkg::CAPB_RESET; // RULE_14
		end else if (cfg_wr && hit_capb) begin
			capb_r <= cfg_wdata & dfc_pkg::CAPB_RW_MASK; // RULE_13 RULE_14
		end
	end

	// Read path; flr drops an answer in flight, registers are untouched
	always_ff @(posedge clk_sys) begin
		if (rst || function_level_reset) begin
			rd_data_r <= dfc_pkg::RD_UNMAPPED;
			rd_valid_r <= 1'b0;
		end else begin
			rd_valid_r <= done && (mmio_rd || cfg_rd); // RULE_15
			if (mmio_rd && hit_fuse) begin
				rd_data_r <= fuse_r;
			end else if (cfg_rd && hit_capb) begin
				rd_data_r <= capb_r;
			end else begin
				rd_data_r <= dfc_pkg::RD_UNMAPPED;
			end
		end
	end

	// Capability outputs straight from register bits; spare bit 22 unused
	// Spare bit is stored like any other and feeds no output  RULE_07
	assign pipe_a_off = fuse_r[dfc_pkg::PIPE_A_BIT]; // RULE_03
	assign pipe_c_off = fuse_r[dfc_pkg::PIPE_C_BIT]; // RULE_04
	assign pm_off = fuse_r[dfc_pkg::PM_BIT]; // RULE_05
	assign panel_off = fuse_r[dfc_pkg::PANEL_BIT]; // RULE_06
	assign pipe_b_off = fuse_r[dfc_pkg::PIPE_B_BIT]; // RULE_08
	assign aux_display_feature_off = fuse_r[dfc_pkg::AUX_DISP_BIT]; // RULE_09
	assign iso_decode_off = fuse_r[dfc_pkg::ISO_DEC_BIT]; // RULE_10
	assign codec_id_lo = fuse_r[dfc_pkg::CODEC_MSB:dfc_pkg::CODEC_LSB]; // RULE_11
	assign shared_virtual_memory_off = capb_r[dfc_pkg::SVM_BIT]; // RULE_13
	assign rd_data = rd_data_r;
	assign rd_valid = rd_valid_r;
	assign fuse_loaded = done;

	// Checks beside the logic
	fuse_load_a: assert property (@(posedge clk_sys) disable iff (rst) // RULE_15
		load |=> fuse_r == $past(fuse_word))
		else $error("fuse register did not take the pin value");
	flr_keep_a: assert property (@(posedge clk_sys) disable iff (rst) // RULE_02
		function_level_reset && !load && !(mmio_wr && hit_fuse) |=> $stable(fuse_r))
		else $error("function level reset disturbed fuse register");
	fuse_wr_a: assert property (@(posedge clk_sys) disable iff (rst) // RULE_01
		mmio_wr && hit_fuse && !load |=> fuse_r == $past(mmio_wdata))
		else $error("fuse register write lost");
	rd_fuse_a: assert property (@(posedge clk_sys) disable iff (rst) // RULE_01
		mmio_rd && hit_fuse && !function_level_reset ##1 !function_level_reset |-> rd_valid && rd_data == $past(fuse_r))
		else $error("fuse register read wrong");
	rd_gate_a: assert property (@(posedge clk_sys) disable iff (rst) // RULE_15
		!done |=> !rd_valid)
		else $error("read answered before fuse load");
	pipe_bits_a: assert property (@(posedge clk_sys) disable iff (rst) // RULE_03
		{pipe_a_off, pipe_b_off, pipe_c_off} ==
		{fuse_r[dfc_pkg::PIPE_A_BIT], fuse_r[dfc_pkg::PIPE_B_BIT],
		fuse_r[dfc_pkg::PIPE_C_BIT]})
		else $error("pipe disable outputs wrong");
	pm_panel_a: assert property (@(posedge clk_sys) disable iff (rst) // RULE_05
		{pm_off, panel_off, aux_display_feature_off, iso_decode_off,
		codec_id_lo} == {fuse_r[dfc_pkg::PM_BIT], fuse_r[dfc_pkg::PANEL_BIT],
		fuse_r[dfc_pkg::AUX_DISP_BIT], fuse_r[dfc_pkg::ISO_DEC_BIT],
		fuse_r[dfc_pkg::CODEC_MSB:dfc_pkg::CODEC_LSB]})
		else $error("feature disable outputs wrong");
	capb_store_a: assert property (@(posedge clk_sys) disable iff (rst) // RULE_14
		cfg_wr && hit_capb |=>
		capb_r == ($past(cfg_wdata) & dfc_pkg::CAPB_RW_MASK)
		&& shared_virtual_memory_off == $past(cfg_wdata[dfc_pkg::SVM_BIT]))
		else $error("capability word b store wrong");
	capb_reset_a: assert property (@(posedge clk_sys) // RULE_13
		$past(rst) |-> capb_r == dfc_pkg::CAPB_RESET
		&& !shared_virtual_memory_off)
		else $error("capability word b reset value wrong");

	// A function level reset only drops the answer in flight
	flr_drop_a: assert property (@(posedge clk_sys) disable iff (rst) // RULE_02
		function_level_reset |=> !rd_valid)
		else $error("answer survived function level reset");

	// Every read strobe after the load, outside a function level reset, gets an answer in the next cycle
	rd_answer_a: assert property (@(posedge clk_sys) disable iff (rst) // RULE_15
		done && (mmio_rd || cfg_rd) && !function_level_reset |=> rd_valid)
		else $error("read strobe got no answer");

	// Unmapped reads answer with zero so software never sees stale data
	rd_unmap_a: assert property (@(posedge clk_sys) disable iff (rst) // RULE_01
		done && mmio_rd && !hit_fuse && !(cfg_rd && hit_capb) && !function_level_reset
		|=> rd_valid && rd_data == dfc_pkg::RD_UNMAPPED)
		else $error("unmapped read returned data");

	// Config read of capability word b returns the stored value
	rd_capb_a: assert property (@(posedge clk_sys) disable iff (rst) // RULE_13
		cfg_rd && hit_capb && !mmio_rd && !function_level_reset |=> rd_data == $past(capb_r))
		else $error("capability word b read wrong");

	// Spare bit is plain storage even though nothing uses it
	spare_store_a: assert property (@(posedge clk_sys) disable iff (rst) // RULE_07
		mmio_wr && hit_fuse && !load |=>
		fuse_r[dfc_pkg::SPARE_BIT] == $past(mmio_wdata[dfc_pkg::SPARE_BIT]))
		else $error("spare bit not stored");

	// Codec field reset value is replaced by the downloaded one
	codec_load_a: assert property (@(posedge clk_sys) disable iff (rst) // RULE_12
		load |=> codec_id_lo ==
		$past(fuse_word[dfc_pkg::CODEC_MSB:dfc_pkg::CODEC_LSB]))
		else $error("codec field not downloaded");

	// Before the load nothing may disturb the fuse register
	fuse_gate_a: assert property (@(posedge clk_sys) disable iff (rst) // RULE_15
		!done && !load |=> $stable(fuse_r))
		else $error("fuse register changed before load");

	// Config writes before the load are refused
	capb_gate_a: assert property (@(posedge clk_sys) disable iff (rst) // RULE_14
		!done |=> $stable(capb_r))
		else $error("capability word b changed before load");

	// Capability word b only changes on a config write that hits it
	capb_hold_a: assert property (@(posedge clk_sys) disable iff (rst) // RULE_14
		!(cfg_wr && hit_capb) |=> $stable(capb_r))
		else $error("capability word b changed without write");

	// Fuse register holds unless loaded or written, flr or not
	fuse_hold_a: assert property (@(posedge clk_sys) disable iff (rst) // RULE_02
		!load && !(mmio_wr && hit_fuse) |=> $stable(fuse_r))
		else $error("fuse register changed without write");

	// Writes to other MMIO addresses leave the fuse register alone
	wr_nohit_a: assert property (@(posedge clk_sys) disable iff (rst) // RULE_01
		mmio_wr && !hit_fuse && !load |=> $stable(fuse_r))
		else $error("stray write reached fuse register");

	// Loaded state is kept until the next global reset
	done_hold_a: assert property (@(posedge clk_sys) disable iff (rst) // RULE_15
		done |=> done)
		else $error("fuse loaded flag dropped");

	// A single load pulse per reset, followed by the loaded flag
	load_once_a: assert property (@(posedge clk_sys) disable iff (rst) // RULE_15
		load |=> !load && done)
		else $error("fuse load pulse wrong");
endmodule // dfc_regs
